// [design/mm_pkg.sv]
// Constants and types shared by the memory map decoder and its two memories.
// Assumes one 200 MHz system clock and a single processor initiator.
package mm_pkg;
	localparam int CLK_KHZ          = 200000;
	// Highest flash rate for 16-bit fetches; a 32-bit fetch takes two accesses
	localparam int FLASH_FAST_KHZ   = 41780;
	localparam int FLASH_SLOW_KHZ   = 20890;
	localparam int FLASH_ACC_CYCLES = (CLK_KHZ + FLASH_FAST_KHZ - 1) / FLASH_FAST_KHZ;
	localparam int HP_CYCLES        = 1;
	localparam int PB_CYCLES        = 2;
	localparam int SRAM_WORDS       = 2048;
	localparam int FLASH_BANK_HW    = 32768;
	localparam int FLASH_PAGE_BYTES = 512;
	localparam int FLASH_BOOT_BYTES = 2048;
	localparam int FLASH_BOOT_HW    = FLASH_BANK_HW - FLASH_BOOT_BYTES / 2;
	localparam logic [31:0] SRAM_BYTES  = 32'h0000_2000;
	localparam logic [31:0] FLASH_BYTES = 32'h0002_0000;
	localparam logic [31:0] ZERO_BASE   = 32'h0000_0000;
	localparam logic [15:0] MMR_PAGE    = 16'hFFFF;
	localparam logic [15:0] REMAP_OFS   = 16'h0220;
	localparam logic [7:0]  REMAP_RESET = 8'h01;
	localparam int REMAP_FLASH_BIT      = 0;
	// Regions: irq, sysctl, timers, clock/power, supply monitor, reference,
	// converter, output converter, serial 0, serial 1, gpio, flash control
	localparam int N_REGIONS = 12;
	localparam logic [15:0] REGION_LO [N_REGIONS] = '{16'h0000, 16'h0200, 16'h0300, 16'h0400,
		16'h0440, 16'h0480, 16'h0500, 16'h0670, 16'h0700, 16'h0740, 16'h0D00, 16'h0E00};
	localparam logic [15:0] REGION_HI [N_REGIONS] = '{16'h0200, 16'h0300, 16'h0400, 16'h0440,
		16'h0480, 16'h04C0, 16'h0600, 16'h0700, 16'h0740, 16'h0780, 16'h0E00, 16'h0F00};
	localparam logic [N_REGIONS-1:0] REGION_SLOW = 12'h3FC;
	typedef enum logic [1:0] {SIZE_BYTE = 2'b00, SIZE_HALF = 2'b01, SIZE_WORD = 2'b10} size_type;
	typedef enum logic [2:0] {TGT_NONE = 3'b000, TGT_SRAM = 3'b001, TGT_FLASH = 3'b010,
		TGT_HP = 3'b011, TGT_PB = 3'b100, TGT_REMAP = 3'b101} target_type;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_PHASE = 2'b01, ST_DONE = 2'b10} state_type;
	typedef enum logic [1:0] {FL_IDLE = 2'b00, FL_LOW = 2'b01, FL_HIGH = 2'b10} flash_state_type;
endpackage

// [design/mem_port_if.sv]
// Request and answer port between the decoder and one memory.
// Assumes both ends run on the same clock.
interface mem_port_if;
	logic        req;
	logic        we;
	logic [1:0]  size;
	logic [16:0] addr;
	logic [3:0]  be;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        done;
	modport initiator (output req, we, size, addr, be, wdata, input rdata, done);
	modport target (input req, we, size, addr, be, wdata, output rdata, done);
endinterface

// [design/sram_array.sv]
// Word-wide SRAM with byte write enables and registered read data.
// Assumes req is a one-cycle pulse; done follows one cycle later.
module sram_array #(
	parameter int WORDS = mm_pkg::SRAM_WORDS
) (
	input  wire logic   i_clk,
	input  wire logic   i_reset_n,
	mem_port_if.target  port
);
	localparam int AW = $clog2(WORDS);
	logic [31:0]   mem [WORDS];
	logic [31:0]   rdata_q;
	logic          done_q;
	logic [AW-1:0] idx;

	assign idx = port.addr[AW+1:2];

	// Whole word in one access at full clock rate
	always_ff @(posedge i_clk)
	begin
		if (port.req)
		begin
			for (int b = 0; b < 4; b++)
			begin
				if (port.we && port.be[b])
					mem[idx][8*b +: 8] <= port.wdata[8*b +: 8];
			end
			rdata_q <= mem[idx];
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			done_q <= 1'b0;
		else
			done_q <= port.req;
	end

	assign port.rdata = rdata_q;
	assign port.done  = done_q;
endmodule

// [design/flash_reader.sv]
// Reads the 16-bit flash array, one or two halfword accesses per request.
// Assumes flash data is valid after the access time; writes are not served.
module flash_reader #(
	parameter logic [14:0] BOOT_HW_START = 15'(mm_pkg::FLASH_BOOT_HW)
) (
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	mem_port_if.target       port,
	output logic             o_flash_rd,
	output logic             o_flash_bank,
	output logic [14:0]      o_flash_addr,
	output logic [7:0]       o_flash_page,
	output logic             o_flash_boot_page,
	input  wire logic [15:0] i_flash_rdata
);
	localparam int CW = $clog2(mm_pkg::FLASH_ACC_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LOAD = CW'(mm_pkg::FLASH_ACC_CYCLES - 1);
	mm_pkg::flash_state_type state_q;
	logic [CW-1:0] cnt_q;
	logic [15:0]   hw_addr_q;
	logic [15:0]   lo_q;
	logic [31:0]   data_q;
	logic          two_q;
	logic          done_q;
	logic          start;
	logic          acc_end;

	assign start   = (state_q == mm_pkg::FL_IDLE) && port.req && !port.we;
	assign acc_end = (state_q != mm_pkg::FL_IDLE) && (cnt_q == '0);

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			state_q <= mm_pkg::FL_IDLE;
		else
			case (state_q)
				mm_pkg::FL_IDLE: if (start) state_q <= mm_pkg::FL_LOW;
				mm_pkg::FL_LOW:  if (acc_end) state_q <= two_q ? mm_pkg::FL_HIGH : mm_pkg::FL_IDLE;
				mm_pkg::FL_HIGH: if (acc_end) state_q <= mm_pkg::FL_IDLE;
				default:         state_q <= mm_pkg::FL_IDLE;
			endcase
	end

	// Each halfword access is held for the flash access time
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			cnt_q <= '0;
		else if (start || (acc_end && state_q == mm_pkg::FL_LOW && two_q))
			cnt_q <= CNT_LOAD;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			hw_addr_q <= '0;
			two_q     <= 1'b0;
			lo_q      <= '0;
			data_q    <= '0;
		end
		else if (start)
		begin
			hw_addr_q <= {port.addr[16:2], port.size[1] ? 1'b0 : port.addr[1]};
			two_q     <= port.size[1];
		end
		else if (acc_end && state_q == mm_pkg::FL_LOW)
		begin
			lo_q   <= i_flash_rdata;
			data_q <= {i_flash_rdata, i_flash_rdata};
			if (two_q)
				hw_addr_q[0] <= 1'b1;
		end
		else if (acc_end)
			data_q <= {i_flash_rdata, lo_q};
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			done_q <= 1'b0;
		else
			done_q <= (port.req && port.we && state_q == mm_pkg::FL_IDLE)
				|| (acc_end && (state_q == mm_pkg::FL_HIGH || !two_q));
	end

	assign port.rdata        = data_q;
	assign port.done         = done_q;
	assign o_flash_rd        = (state_q != mm_pkg::FL_IDLE);
	assign o_flash_bank      = hw_addr_q[15];
	assign o_flash_addr      = hw_addr_q[14:0];
	assign o_flash_page      = hw_addr_q[15:8];
	assign o_flash_boot_page = o_flash_rd && !hw_addr_q[15] && (hw_addr_q[14:0] >= BOOT_HW_START);
endmodule

// [design/memory_map_decoder.sv]
// System address decoder: SRAM, flash, remap register and peripheral regions.
// Assumes the processor holds a request until o_ready and then waits for o_done.

module memory_map_decoder #(
	parameter logic [31:0] SRAM_BASE   = 32'h0001_0000,
	parameter logic [31:0] FLASH_BASE  = 32'h0008_0000,
	parameter logic [31:0] ALIAS_BYTES = 32'h0002_0000
) (
	input  wire logic                        i_clk,
	input  wire logic                        i_reset_n,
	input  wire logic                        i_req,
	input  wire logic                        i_we,
	input  wire logic [1:0]                  i_size,
	input  wire logic [31:0]                 i_addr,
	input  wire logic [31:0]                 i_wdata,
	output logic                             o_ready,
	output logic                             o_done,
	output logic [31:0]                      o_rdata,
	output logic                             o_hp_sel,
	output logic                             o_pb_sel,
	output logic [mm_pkg::N_REGIONS-1:0]     o_per_region,
	output logic [15:0]                      o_per_addr,
	output logic                             o_per_we,
	output logic [3:0]                       o_per_be,
	output logic [31:0]                      o_per_wdata,
	input  wire logic [31:0]                 i_hp_rdata,
	input  wire logic [31:0]                 i_pb_rdata,
	output logic                             o_flash_rd,
	output logic                             o_flash_bank,
	output logic [14:0]                      o_flash_addr,
	output logic [7:0]                       o_flash_page,
	output logic                             o_flash_boot_page,
	input  wire logic [15:0]                 i_flash_rdata
);
	mm_pkg::state_type               state_q;
	mm_pkg::target_type              tgt_q;
	mm_pkg::target_type              take_tgt;
	logic [mm_pkg::N_REGIONS-1:0]    take_hits;
	logic [mm_pkg::N_REGIONS-1:0]    take_region;
	logic [16:0]                     take_ofs;
	logic [mm_pkg::N_REGIONS-1:0]    region_q;
	logic [31:0]                     addr_q;
	logic                            we_q;
	logic [1:0]                      size_q;
	logic [3:0]                      be_q;
	logic [31:0]                     wdata_q;
	logic [16:0]                     mem_ofs_q;
	logic [1:0]                      cnt_q;
	logic [31:0]                     rdata_q;
	logic [7:0]                      remap_q;
	logic                            sram_req_q;
	logic                            flash_req_q;
	logic                            take;
	logic                            phase_end;
	logic [31:0]                     word;

	mem_port_if sram_port ();
	mem_port_if flash_port ();

	function automatic logic [3:0] byte_enables(input logic [1:0] size, input logic [1:0] ofs);
		logic [3:0] m;
		case (size)
			mm_pkg::SIZE_BYTE: m = 4'h1 << ofs;
			mm_pkg::SIZE_HALF: m = 4'h3 << {ofs[1], 1'b0};
			default:           m = 4'hF;
		endcase
		return m;
	endfunction

	// Small data is copied to every lane so the enabled lane sees it
	function automatic logic [31:0] lane_write(input logic [1:0] size, input logic [31:0] w);
		logic [31:0] r;
		case (size)
			mm_pkg::SIZE_BYTE: r = {4{w[7:0]}};
			mm_pkg::SIZE_HALF: r = {2{w[15:0]}};
			default:           r = w;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] align_read(input logic [31:0] w, input logic [1:0] ofs,
		input logic [1:0] size);
		logic [31:0] s;
		logic [31:0] r;
		s = w >> {ofs, 3'b000};
		case (size)
			mm_pkg::SIZE_BYTE: r = {24'h000000, s[7:0]};
			mm_pkg::SIZE_HALF: r = {16'h0000, s[15:0]};
			default:           r = w;
		endcase
		return r;
	endfunction

	// Wrapping subtraction makes one compare per range
	function automatic logic in_range(input logic [31:0] a, input logic [31:0] base,
		input logic [31:0] len);
		logic [31:0] d;
		d = a - base;
		return d < len;
	endfunction

	function automatic logic [mm_pkg::N_REGIONS-1:0] region_hits(input logic [15:0] ofs);
		logic [mm_pkg::N_REGIONS-1:0] h;
		h = '0;
		for (int i = 0; i < mm_pkg::N_REGIONS; i++)
			h[i] = (ofs >= mm_pkg::REGION_LO[i]) && (ofs < mm_pkg::REGION_HI[i]);
		return h;
	endfunction

	assign take = (state_q == mm_pkg::ST_IDLE) && i_req;

	// Decode of the address presented in the take cycle
	always_comb
	begin
		take_tgt    = mm_pkg::TGT_NONE;
		take_ofs    = '0;
		take_region = '0;
		take_hits   = region_hits(i_addr[15:0]);
		if (i_addr[31:16] == mm_pkg::MMR_PAGE)
		begin
			if (i_addr[15:2] == mm_pkg::REMAP_OFS[15:2])
				take_tgt = mm_pkg::TGT_REMAP;
			else if (|take_hits)
			begin
				take_region = take_hits;
				if (|(take_hits & mm_pkg::REGION_SLOW))
					take_tgt = mm_pkg::TGT_PB;
				else
					take_tgt = mm_pkg::TGT_HP;
			end
		end
		else if (in_range(i_addr, SRAM_BASE, mm_pkg::SRAM_BYTES))
		begin
			take_tgt = mm_pkg::TGT_SRAM;
			take_ofs = 17'(i_addr - SRAM_BASE);
		end
		else if (in_range(i_addr, FLASH_BASE, mm_pkg::FLASH_BYTES))
		begin
			take_tgt = mm_pkg::TGT_FLASH;
			take_ofs = 17'(i_addr - FLASH_BASE);
		end
		else if (in_range(i_addr, mm_pkg::ZERO_BASE, ALIAS_BYTES))
		begin
			take_ofs = i_addr[16:0];
			if (remap_q[mm_pkg::REMAP_FLASH_BIT])
				take_tgt = mm_pkg::TGT_FLASH;
			else
				take_tgt = mm_pkg::TGT_SRAM;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			state_q <= mm_pkg::ST_IDLE;
		else
			case (state_q)
				mm_pkg::ST_IDLE:  if (take) state_q <= mm_pkg::ST_PHASE;
				mm_pkg::ST_PHASE: if (phase_end) state_q <= mm_pkg::ST_DONE;
				mm_pkg::ST_DONE:  state_q <= mm_pkg::ST_IDLE;
				default:          state_q <= mm_pkg::ST_IDLE;
			endcase
	end

	// Request is held in flops so every bus output comes from a register
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			tgt_q     <= mm_pkg::TGT_NONE;
			region_q  <= '0;
			addr_q    <= '0;
			we_q      <= 1'b0;
			size_q    <= 2'b00;
			be_q      <= 4'h0;
			wdata_q   <= '0;
			mem_ofs_q <= '0;
		end
		else if (take)
		begin
			tgt_q     <= take_tgt;
			region_q  <= take_region;
			addr_q    <= i_addr;
			we_q      <= i_we;
			size_q    <= i_size;
			be_q      <= byte_enables(i_size, i_addr[1:0]);
			wdata_q   <= lane_write(i_size, i_wdata);
			mem_ofs_q <= take_ofs;
		end
	end

	// Bus phase length in cycles
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			cnt_q <= 2'b00;
		else if (take)
		begin
			if (take_tgt == mm_pkg::TGT_PB)
				cnt_q <= 2'(mm_pkg::PB_CYCLES - 1);
			else
				cnt_q <= 2'(mm_pkg::HP_CYCLES - 1);
		end
		else if (state_q == mm_pkg::ST_PHASE && cnt_q != 2'b00)
			cnt_q <= cnt_q - 2'b01;
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			sram_req_q  <= 1'b0;
			flash_req_q <= 1'b0;
		end
		else
		begin
			sram_req_q  <= take && (take_tgt == mm_pkg::TGT_SRAM);
			flash_req_q <= take && (take_tgt == mm_pkg::TGT_FLASH);
		end
	end

	always_comb
	begin
		case (tgt_q)
			mm_pkg::TGT_HP,
			mm_pkg::TGT_PB:    phase_end = (cnt_q == 2'b00);
			mm_pkg::TGT_SRAM:  phase_end = sram_port.done;
			mm_pkg::TGT_FLASH: phase_end = flash_port.done;
			default:           phase_end = 1'b1;
		endcase
	end

	// Unassigned space answers zero
	always_comb
	begin
		case (tgt_q)
			mm_pkg::TGT_HP:    word = i_hp_rdata;
			mm_pkg::TGT_PB:    word = i_pb_rdata;
			mm_pkg::TGT_SRAM:  word = sram_port.rdata;
			mm_pkg::TGT_FLASH: word = flash_port.rdata;
			mm_pkg::TGT_REMAP: word = {24'h000000, remap_q};
			default:           word = '0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			rdata_q <= '0;
		else if (state_q == mm_pkg::ST_PHASE && phase_end)
			rdata_q <= we_q ? 32'h0000_0000 : align_read(word, addr_q[1:0], size_q);
	end

	// Only bit 0 is kept; upper bits read zero
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			remap_q <= mm_pkg::REMAP_RESET;
		else if (state_q == mm_pkg::ST_PHASE && tgt_q == mm_pkg::TGT_REMAP && we_q && be_q[0])
			remap_q <= {7'h00, wdata_q[mm_pkg::REMAP_FLASH_BIT]};
	end

	assign sram_port.req   = sram_req_q;
	assign sram_port.we    = we_q;
	assign sram_port.size  = size_q;
	assign sram_port.addr  = mem_ofs_q;
	assign sram_port.be    = be_q;
	assign sram_port.wdata = wdata_q;

	assign flash_port.req   = flash_req_q;
	assign flash_port.we    = we_q;
	assign flash_port.size  = size_q;
	assign flash_port.addr  = mem_ofs_q;
	assign flash_port.be    = be_q;
	assign flash_port.wdata = wdata_q;

	sram_array #(
		.WORDS (mm_pkg::SRAM_WORDS)
	) u_sram (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.port      (sram_port.target)
	);

	flash_reader u_flash (
		.i_clk             (i_clk),
		.i_reset_n         (i_reset_n),
		.port              (flash_port.target),
		.o_flash_rd        (o_flash_rd),
		.o_flash_bank      (o_flash_bank),
		.o_flash_addr      (o_flash_addr),
		.o_flash_page      (o_flash_page),
		.o_flash_boot_page (o_flash_boot_page),
		.i_flash_rdata     (i_flash_rdata)
	);

	// Strobes last exactly the bus phase; no strobe reaches reserved space
	assign o_hp_sel     = (state_q == mm_pkg::ST_PHASE) && (tgt_q == mm_pkg::TGT_HP);
	assign o_pb_sel     = (state_q == mm_pkg::ST_PHASE) && (tgt_q == mm_pkg::TGT_PB);
	assign o_per_region = region_q;
	assign o_per_addr   = addr_q[15:0];
	assign o_per_we     = we_q;
	assign o_per_be     = be_q;
	assign o_per_wdata  = wdata_q;
	assign o_ready      = (state_q == mm_pkg::ST_IDLE);
	assign o_done       = (state_q == mm_pkg::ST_DONE);
	assign o_rdata      = rdata_q;
endmodule

// [tb/memory_map_decoder_checker.sv]
// Port-level assertions for the memory map decoder.
// Assumes one clock and the asynchronous active-low reset of the top module.
module memory_map_decoder_checker (
	input wire logic        i_clk,
	input wire logic        i_reset_n,
	input wire logic        i_req,
	input wire logic        o_ready,
	input wire logic        o_done,
	input wire logic        o_hp_sel,
	input wire logic        o_pb_sel,
	input wire logic [11:0] o_per_region,
	input wire logic [15:0] o_per_addr,
	input wire logic        o_flash_rd,
	input wire logic        o_flash_bank,
	input wire logic [14:0] o_flash_addr,
	input wire logic [7:0]  o_flash_page,
	input wire logic        o_flash_boot_page
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	property p_hp_one;
		o_hp_sel |=> !o_hp_sel && o_done;
	endproperty
	a_hp_one: assert property (p_hp_one) else $error("fast bus phase not one cycle");
	property p_pb_two;
		$rose(o_pb_sel) |-> o_pb_sel ##1 o_pb_sel ##1 (!o_pb_sel && o_done);
	endproperty
	a_pb_two: assert property (p_pb_two) else $error("peripheral phase not two cycles");
	property p_hp_route;
		o_hp_sel |-> $onehot(o_per_region) && (o_per_region & 12'h3FC) == 12'h000;
	endproperty
	a_hp_route: assert property (p_hp_route) else $error("slow region on fast bus");
	property p_pb_route;
		o_pb_sel |-> $onehot(o_per_region) && (o_per_region & 12'hC03) == 12'h000;
	endproperty
	a_pb_route: assert property (p_pb_route) else $error("fast region on peripheral bus");
	property p_irq_base;
		o_hp_sel && o_per_region[0] |-> o_per_addr < 16'h0200;
	endproperty
	a_irq_base: assert property (p_irq_base) else $error("interrupt region misplaced");
	property p_timer_base;
		o_pb_sel && o_per_region[2] |-> o_per_addr[15:8] == 8'h03;
	endproperty
	a_timer_base: assert property (p_timer_base) else $error("timer region misplaced");
	property p_serial_base;
		o_pb_sel && (o_per_region[8] || o_per_region[9]) |-> o_per_addr[15:7] == 9'h00E
			&& o_per_addr[6] == o_per_region[9];
	endproperty
	a_serial_base: assert property (p_serial_base) else $error("serial region misplaced");
	property p_flash_time;
		$rose(o_flash_rd) |-> o_flash_rd [*5];
	endproperty
	a_flash_time: assert property (p_flash_time) else $error("flash access too short");
	property p_flash_page;
		o_flash_rd |-> o_flash_page == {o_flash_bank, o_flash_addr[14:8]};
	endproperty
	a_flash_page: assert property (p_flash_page) else $error("flash page number wrong");
	property p_boot;
		o_flash_boot_page == (o_flash_rd && !o_flash_bank && o_flash_addr >= 15'h7C00);
	endproperty
	a_boot: assert property (p_boot) else $error("boot page flag wrong");
	property p_take;
		i_req && o_ready |-> ##[2:13] o_done;
	endproperty
	a_take: assert property (p_take) else $error("no answer in time");
	property p_done_free;
		o_done |=> o_ready && !o_done;
	endproperty
	a_done_free: assert property (p_done_free) else $error("not idle after answer");
endmodule

bind memory_map_decoder memory_map_decoder_checker memory_map_decoder_checker_inst (
	.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req), .o_ready(o_ready), .o_done(o_done),
	.o_hp_sel(o_hp_sel), .o_pb_sel(o_pb_sel), .o_per_region(o_per_region), .o_per_addr(o_per_addr),
	.o_flash_rd(o_flash_rd), .o_flash_bank(o_flash_bank), .o_flash_addr(o_flash_addr),
	.o_flash_page(o_flash_page), .o_flash_boot_page(o_flash_boot_page));

// [tb/bus_memory_model.sv]
// Flash array and register bus responders facing the decoder.
// Assumes combinational answers; released lines show the inverted pattern.
module bus_memory_model (
	input  wire logic        i_flash_rd,
	input  wire logic        i_flash_bank,
	input  wire logic [14:0] i_flash_addr,
	input  wire logic        i_hp_sel,
	input  wire logic        i_pb_sel,
	input  wire logic [15:0] i_per_addr,
	output logic [15:0]      o_flash_rdata,
	output logic [31:0]      o_hp_rdata,
	output logic [31:0]      o_pb_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// Each halfword holds its own bank and address, so pairing errors show
	assign o_flash_rdata = i_flash_rd ? {i_flash_bank, i_flash_addr} : ~{i_flash_bank, i_flash_addr};
	assign o_hp_rdata = i_hp_sel ? {16'hA5A5, i_per_addr} : ~{16'hA5A5, i_per_addr};
	assign o_pb_rdata = i_pb_sel ? {16'h5A5A, i_per_addr} : ~{16'h5A5A, i_per_addr};
endmodule

// [tb/test_memory_map_decoder.sv]
// Directed test of the memory map decoder through its request port.
// Assumes the bus model answers flash and both register buses.
module test_memory_map_decoder;
	timeunit 1ns;
	timeprecision 100ps;
	logic        i_clk = 0, i_reset_n = 0, i_req = 0, i_we = 0;
	logic [1:0]  i_size = 2'h2;
	logic [31:0] i_addr = 32'h0, i_wdata = 32'h0;
	logic        o_ready, o_done, o_hp_sel, o_pb_sel, o_per_we, o_flash_rd, o_flash_bank, o_flash_boot_page;
	logic [11:0] o_per_region, reg_seen;
	logic [15:0] o_per_addr, i_flash_rdata;
	logic [3:0]  o_per_be;
	logic [31:0] o_rdata, o_per_wdata, i_hp_rdata, i_pb_rdata, rd;
	logic [14:0] o_flash_addr;
	logic [7:0]  o_flash_page;
	int          miscompares = 0, compares = 0, lat;
	localparam logic [15:0] OFS [14] = '{16'h0000, 16'h0100, 16'h0230, 16'h0300, 16'h0400, 16'h0440,
		16'h0480, 16'h0500, 16'h0670, 16'h0700, 16'h0740, 16'h0D00, 16'h0E00, 16'h0800};
	localparam int RBIT [14] = '{0, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12};

	always #2.5 i_clk = ~i_clk;

	memory_map_decoder memory_map_decoder_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req),
		.i_we(i_we), .i_size(i_size), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready),
		.o_done(o_done), .o_rdata(o_rdata), .o_hp_sel(o_hp_sel), .o_pb_sel(o_pb_sel),
		.o_per_region(o_per_region), .o_per_addr(o_per_addr), .o_per_we(o_per_we), .o_per_be(o_per_be),
		.o_per_wdata(o_per_wdata), .i_hp_rdata(i_hp_rdata), .i_pb_rdata(i_pb_rdata),
		.o_flash_rd(o_flash_rd), .o_flash_bank(o_flash_bank), .o_flash_addr(o_flash_addr),
		.o_flash_page(o_flash_page), .o_flash_boot_page(o_flash_boot_page), .i_flash_rdata(i_flash_rdata));
	bus_memory_model bus_memory_model_inst (.i_flash_rd(o_flash_rd), .i_flash_bank(o_flash_bank),
		.i_flash_addr(o_flash_addr), .i_hp_sel(o_hp_sel), .i_pb_sel(o_pb_sel), .i_per_addr(o_per_addr),
		.o_flash_rdata(i_flash_rdata), .o_hp_rdata(i_hp_rdata), .o_pb_rdata(i_pb_rdata));

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Request held until taken; latency counted from the take edge to o_done
	task automatic access(input logic we, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_req <= 1'b1;
		i_we <= we;
		i_size <= sz;
		i_addr <= a;
		i_wdata <= d;
		do @(negedge i_clk); while (o_ready !== 1'b1);
		@(posedge i_clk);
		i_req <= 1'b0;
		lat = 0;
		do
		begin
			@(negedge i_clk);
			lat++;
			if (lat == 1)
				reg_seen = o_per_region;
		end
		while (o_done !== 1'b1 && lat < 40);
		rd = o_rdata;
	endtask

	task automatic rdchk(input logic [31:0] a, input logic [1:0] sz, input logic [31:0] exp, input int el);
		access(1'b0, sz, a, 32'h0);
		check(rd, exp, "read data");
		check(32'(lat), 32'(el), "latency");
	endtask

	task automatic wrchk(input logic [31:0] a, input logic [1:0] sz, input logic [31:0] d, input int el);
		access(1'b1, sz, a, d);
		check(32'(lat), 32'(el), "write latency");
	endtask

	task automatic do_reset();
		// Reset is applied on a rising edge like every other input
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		repeat (8) @(posedge i_clk);
		i_reset_n <= 1'b1;
	endtask

	initial
	begin
		#(5 * 4000);
		miscompares++;
		summarize();
	end

	initial
	begin
		do_reset();
		rdchk(32'hFFFF_0220, 2'h0, 32'h0000_0001, 2);
		rdchk(32'h0000_0000, 2'h2, 32'h0001_0000, 13);
		rdchk(32'h0008_0012, 2'h1, 32'h0000_0009, 8);
		rdchk(32'h0009_0004, 2'h2, 32'h8003_8002, 13);
		rdchk(32'h0008_0301, 2'h0, 32'h0000_0001, 8);
		rdchk(32'h0008_F800, 2'h1, 32'h0000_7C00, 8);
		wrchk(32'h0008_0000, 2'h2, 32'h1234_5678, 3);
		rdchk(32'h0008_0000, 2'h2, 32'h0001_0000, 13);
		$display("test flash done");
		wrchk(32'h0001_0000, 2'h2, 32'h4433_2211, 3);
		rdchk(32'h0001_0002, 2'h0, 32'h0000_0033, 3);
		rdchk(32'h0001_0002, 2'h1, 32'h0000_4433, 3);
		rdchk(32'h0001_0000, 2'h2, 32'h4433_2211, 3);
		$display("test sram done");
		wrchk(32'hFFFF_0220, 2'h0, 32'h0000_00FE, 2);
		rdchk(32'hFFFF_0220, 2'h0, 32'h0000_0000, 2);
		rdchk(32'h0000_0000, 2'h2, 32'h4433_2211, 3);
		rdchk(32'h0008_0000, 2'h2, 32'h0001_0000, 13);
		rdchk(32'h0001_0000, 2'h2, 32'h4433_2211, 3);
		do_reset();
		rdchk(32'h0000_0000, 2'h2, 32'h0001_0000, 13);
		$display("test remap done");
		// Every region base but sysctl is touched, irq and sysctl also inside, plus one deliberate hole
		for (int i = 0; i < 14; i++)
		begin
			if (i == 13)
				rdchk({16'hFFFF, OFS[i]}, 2'h2, 32'h0, 2);
			else if (RBIT[i] < 2 || RBIT[i] > 9)
				rdchk({16'hFFFF, OFS[i]}, 2'h2, {16'hA5A5, OFS[i]}, 2);
			else
				rdchk({16'hFFFF, OFS[i]}, 2'h2, {16'h5A5A, OFS[i]}, 3);
			check(32'(reg_seen), (i == 13) ? 32'h0 : 32'(1) << RBIT[i], "region");
		end
		rdchk(32'h4000_0000, 2'h2, 32'h0, 2);
		wrchk(32'hFFFF_0701, 2'h0, 32'h0000_00AB, 3);
		check(32'(o_per_be), 32'h2, "byte lane");
		check(o_per_wdata, 32'hABAB_ABAB, "lane data");
		check(32'(o_per_we), 32'h1, "write strobe");
		$display("test registers done");
		summarize();
	end
endmodule
